// >>> rtl/pwmc_codec.sv
// pwm carrier codec: signature/frame encoder and frame decoder
// assumes ppsIn and tx requests come from ref_clk logic; carrier and pwm input are asynchronous
//
// How it works
// - encoder keeps carrier rising edges untouched
// - space unmodulated, zero 25%, one 75%
// - 8-symbol signature, reject leading space
// - signature mode sends no frames
// - signature starts right after one-second pulse
// - frame: 23-bit header, 88 payload, parity
// - parity over whole frame, checked on receive
// - header: command, source, broadcast, destination
// - pps/time code in hardware; clock-sync code only via txCmd
// - read code 010, write code chosen 100
// - source field holds local encoder identifier
// - broadcast frames bypass destination match
// - any of four accumulators selectable
// - pps/time frame right after pulse
// - decoder may emit one-second pulse
// - any dpll as sync source/target
// - remote frames: address bytes 0-1, data 2-10
// - time payload in 48/32/8 format
`timescale 1ns/1ps
`include "pwmc_map.svh"
module pwmc_codec (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // carrier pins
   input wire logic carrierIn,
   output logic pwmOut,
   input wire logic pwmIn,
   // encoder control
   input wire logic sigModeEn,
   input wire logic [15:0] sigPattern,
   output logic sigReject,
   input wire logic ppsIn,
   input wire logic [3:0][87:0] todIn,
   input wire logic [1:0] encTodSel,
   input wire logic [7:0] localEncoderIdentifier,
   input wire logic broadcastEn,
   input wire logic [7:0] txDstId,
   // encoder request
   input wire logic txReq,
   input wire logic [2:0] txCmd,
   input wire logic [87:0] txPayload,
   output logic txBusy,
   // decoder control
   input wire logic [7:0] localDecoderIdentifier,
   input wire logic ppsGenEn,
   input wire logic [1:0] rxTodSel,
   input wire logic [3:0] rxSyncSel,
   // decoder results
   output logic rxValid,
   output logic [2:0] rxCmd,
   output logic [7:0] rxSrcId,
   output logic rxBroadcast,
   output logic [87:0] rxPayload,
   output logic rxParityErr,
   output logic rxPps,
   output logic [1:0] rxTodTarget,
   output logic [3:0] rxSyncTarget
);
   pwmc_pkg::pwmc_main_s r_ff;
   pwmc_pkg::pwmc_main_s nxt_r;
   pwmc_sym_if symIf ();
   logic sigBad;
   logic rxRise;
   logic [18:0] hi8;
   logic [18:0] per3;
   logic [18:0] per5;
   pwmc_pkg::pwmc_sym_e rxSym;
   logic [`PWMC_FRAME_BITS-1:0] rxFull;
   logic dstOk;

   // header order fixed; reserved header bits go out as zero
   function automatic logic [`PWMC_FRAME_BITS-1:0] pwmc_frame(
      input logic [2:0] cmd,
      input logic [7:0] src,
      input logic bc,
      input logic [7:0] dst,
      input logic [87:0] pay
   );
      logic [`PWMC_FRAME_BITS-2:0] body;
      body = {cmd, src, bc, dst, 3'h0, pay};
      return {body, ^body};
   endfunction

   pwmc_sym_tx u_sym_tx (
      .ref_clk(ref_clk),
      .rst(rst),
      .carrierIn(carrierIn),
      .symIf(symIf.enc),
      .pwmOut(pwmOut)
   );

   assign sigBad = sigPattern[15:14] == pwmc_pkg::PWMC_SYM_SPACE;

   // ***************************************************************
   // symbol presented to the encoder
   // ***************************************************************
   always_comb begin
      case (r_ff.txState)
         pwmc_pkg::PWMC_TX_SIG: symIf.sym = pwmc_pkg::pwmc_sym_e'(sigPattern[{~r_ff.sigIdx, 1'b1} -: 2]);
         pwmc_pkg::PWMC_TX_FRAME: symIf.sym = r_ff.txShift[`PWMC_FRAME_BITS-1] ?
            pwmc_pkg::PWMC_SYM_ONE : pwmc_pkg::PWMC_SYM_ZERO;
         default: symIf.sym = pwmc_pkg::PWMC_SYM_SPACE;
      endcase
   end

   // ***************************************************************
   // decoder symbol slicer
   // ***************************************************************
   // thresholds at 3/8 and 5/8 of the period leave margin for sampling jitter
   assign rxRise = r_ff.rS2 & ~r_ff.rLast;
   assign hi8 = {r_ff.hiCnt, 3'h0};
   assign per3 = {3'h0, r_ff.perCnt} + {2'h0, r_ff.perCnt, 1'b0};
   assign per5 = {3'h0, r_ff.perCnt} + {1'b0, r_ff.perCnt, 2'h0};
   assign rxFull = {r_ff.rxShift, rxSym == pwmc_pkg::PWMC_SYM_ONE};
   assign dstOk = rxFull[`PWMC_BC_POS] || rxFull[`PWMC_DST_LSB +: 8] == localDecoderIdentifier;

   always_comb begin
      if (hi8 < per3) begin
         rxSym = pwmc_pkg::PWMC_SYM_ZERO;
      end else if (hi8 > per5) begin
         rxSym = pwmc_pkg::PWMC_SYM_ONE;
      end else begin
         rxSym = pwmc_pkg::PWMC_SYM_SPACE;
      end
   end

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      nxt_r = r_ff;
      nxt_r.sigReject = sigModeEn & sigBad;
      nxt_r.rxValid = 1'b0;
      nxt_r.rxParityErr = 1'b0;
      nxt_r.rxPps = 1'b0;
      // encoder sequencer
      case (r_ff.txState)
         pwmc_pkg::PWMC_TX_IDLE: begin
            // a pulse outranks a request in the same cycle; both are refused while busy
            if (ppsIn && sigModeEn) begin
               if (!sigBad) begin
                  nxt_r.txState = pwmc_pkg::PWMC_TX_SIG;
                  nxt_r.sigIdx = 3'h0;
               end
            end else if (ppsIn) begin
               // accumulator time is expected to carry any carrier offset already
               nxt_r.txShift = pwmc_frame(`PWMC_CMD_PPS, localEncoderIdentifier, broadcastEn, txDstId,
                  todIn[encTodSel]);
               nxt_r.txState = pwmc_pkg::PWMC_TX_FRAME;
               nxt_r.bitCnt = 7'h00;
            end else if (txReq && !sigModeEn) begin
               nxt_r.txShift = pwmc_frame(txCmd, localEncoderIdentifier, broadcastEn, txDstId,
                  txPayload);
               nxt_r.txState = pwmc_pkg::PWMC_TX_FRAME;
               nxt_r.bitCnt = 7'h00;
            end
         end
         pwmc_pkg::PWMC_TX_SIG: begin
            if (symIf.take) begin
               if (r_ff.sigIdx == `PWMC_SIG_LAST) begin
                  nxt_r.txState = pwmc_pkg::PWMC_TX_IDLE;
               end else begin
                  nxt_r.sigIdx = r_ff.sigIdx + 3'h1;
               end
            end
         end
         pwmc_pkg::PWMC_TX_FRAME: begin
            if (symIf.take) begin
               nxt_r.txShift = {r_ff.txShift[`PWMC_FRAME_BITS-2:0], 1'b0};
               if (r_ff.bitCnt == `PWMC_LAST_BIT) begin
                  nxt_r.txState = pwmc_pkg::PWMC_TX_IDLE;
               end else begin
                  nxt_r.bitCnt = r_ff.bitCnt + 7'h01;
               end
            end
         end
         default: nxt_r.txState = pwmc_pkg::PWMC_TX_IDLE;
      endcase
      nxt_r.txBusy = nxt_r.txState != pwmc_pkg::PWMC_TX_IDLE;
      // decoder
      nxt_r.rS1 = pwmIn;
      nxt_r.rS2 = r_ff.rS1;
      nxt_r.rLast = r_ff.rS2;
      if (rxRise) begin
         nxt_r.hiCnt = 16'h0001;
         nxt_r.perCnt = 16'h0001;
         // frames end after 112 symbols, so back-to-back frames need no space between
         if (!r_ff.rxOn) begin
            if (rxSym != pwmc_pkg::PWMC_SYM_SPACE) begin
               nxt_r.rxOn = 1'b1;
               nxt_r.rxCnt = 7'h01;
               nxt_r.rxShift = {{(`PWMC_FRAME_BITS-2){1'b0}}, rxSym == pwmc_pkg::PWMC_SYM_ONE};
            end
         end else if (rxSym == pwmc_pkg::PWMC_SYM_SPACE) begin
            // a space inside a frame means a broken frame or a signature
            nxt_r.rxOn = 1'b0;
         end else if (r_ff.rxCnt == `PWMC_LAST_BIT) begin
            nxt_r.rxOn = 1'b0;
            if (^rxFull) begin
               nxt_r.rxParityErr = 1'b1;
            end else if (dstOk) begin
               nxt_r.rxValid = 1'b1;
               nxt_r.rxCmd = rxFull[`PWMC_CMD_LSB +: 3];
               nxt_r.rxSrc = rxFull[`PWMC_SRC_LSB +: 8];
               nxt_r.rxBc = rxFull[`PWMC_BC_POS];
               nxt_r.rxDst = rxFull[`PWMC_DST_LSB +: 8];
               nxt_r.rxPay = rxFull[`PWMC_PAY_LSB +: `PWMC_PAY_BITS];
               nxt_r.rxTodTarget = rxTodSel;
               nxt_r.rxSyncTarget = rxSyncSel;
               nxt_r.rxPps = ppsGenEn && rxFull[`PWMC_CMD_LSB +: 3] == `PWMC_CMD_PPS;
            end
         end else begin
            nxt_r.rxShift = rxFull[`PWMC_FRAME_BITS-2:0];
            nxt_r.rxCnt = r_ff.rxCnt + 7'h01;
         end
      end else begin
         if (r_ff.perCnt != `PWMC_CNT_MAX) begin
            nxt_r.perCnt = r_ff.perCnt + 16'h0001;
            if (r_ff.rS2) begin
               nxt_r.hiCnt = r_ff.hiCnt + 16'h0001;
            end
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign sigReject = r_ff.sigReject;
   assign txBusy = r_ff.txBusy;
   assign rxValid = r_ff.rxValid;
   assign rxCmd = r_ff.rxCmd;
   assign rxSrcId = r_ff.rxSrc;
   assign rxBroadcast = r_ff.rxBc;
   assign rxPayload = r_ff.rxPay;
   assign rxParityErr = r_ff.rxParityErr;
   assign rxPps = r_ff.rxPps;
   assign rxTodTarget = r_ff.rxTodTarget;
   assign rxSyncTarget = r_ff.rxSyncTarget;

   // ***************************************************************
   // checks
   // ***************************************************************
   sequence sPpsFramed;
      r_ff.txState == pwmc_pkg::PWMC_TX_IDLE && ppsIn && !sigModeEn;
   endsequence
   sequence sPpsSig;
      r_ff.txState == pwmc_pkg::PWMC_TX_IDLE && ppsIn && sigModeEn;
   endsequence
   sequence sReqFramed;
      r_ff.txState == pwmc_pkg::PWMC_TX_IDLE && txReq && !ppsIn && !sigModeEn;
   endsequence

   chk_frame_length: assert property (@(posedge ref_clk) disable iff (rst)
      (r_ff.txState == pwmc_pkg::PWMC_TX_FRAME && symIf.take && r_ff.bitCnt == `PWMC_LAST_BIT)
      |=> r_ff.txState == pwmc_pkg::PWMC_TX_IDLE) else $error("frame not 112 symbols");
   chk_sig_reject: assert property (@(posedge ref_clk) disable iff (rst)
      (sPpsSig and sigBad) |=> r_ff.txState == pwmc_pkg::PWMC_TX_IDLE && sigReject)
      else $error("signature with leading space sent");
   chk_sig_start: assert property (@(posedge ref_clk) disable iff (rst)
      (sPpsSig and !sigBad) |=> r_ff.txState == pwmc_pkg::PWMC_TX_SIG && r_ff.sigIdx == 3'h0)
      else $error("signature did not start on pulse");
   chk_sig_no_frame: assert property (@(posedge ref_clk) disable iff (rst)
      (sigModeEn && r_ff.txState == pwmc_pkg::PWMC_TX_IDLE) |=> r_ff.txState != pwmc_pkg::PWMC_TX_FRAME)
      else $error("frame sent in signature mode");
   chk_pps_frame: assert property (@(posedge ref_clk) disable iff (rst)
      sPpsFramed |=> r_ff.txState == pwmc_pkg::PWMC_TX_FRAME
      && r_ff.txShift[`PWMC_CMD_LSB +: 3] == `PWMC_CMD_PPS) else $error("no pps frame after pulse");
   chk_src_ident: assert property (@(posedge ref_clk) disable iff (rst)
      sPpsFramed |=> r_ff.txShift[`PWMC_SRC_LSB +: 8] == $past(localEncoderIdentifier))
      else $error("source field wrong");
   chk_parity_drop: assert property (@(posedge ref_clk) disable iff (rst)
      rxParityErr |-> !rxValid) else $error("bad parity frame delivered");
   chk_dst_match: assert property (@(posedge ref_clk) disable iff (rst)
      (rxValid && !rxBroadcast) |-> r_ff.rxDst == $past(localDecoderIdentifier))
      else $error("foreign frame delivered");
   chk_pps_pulse: assert property (@(posedge ref_clk) disable iff (rst)
      rxPps |-> rxValid && rxCmd == `PWMC_CMD_PPS) else $error("pulse without pps frame");

   // encoder side
   chk_req_frame: assert property (@(posedge ref_clk) disable iff (rst)
      sReqFramed |=> r_ff.txState == pwmc_pkg::PWMC_TX_FRAME
      && r_ff.txShift[`PWMC_CMD_LSB +: 3] == $past(txCmd)) else $error("request frame not loaded");
   chk_frame_parity: assert property (@(posedge ref_clk) disable iff (rst)
      (r_ff.txState == pwmc_pkg::PWMC_TX_IDLE && nxt_r.txState == pwmc_pkg::PWMC_TX_FRAME) |=> !(^r_ff.txShift))
      else $error("sent frame parity odd");
   chk_sig_length: assert property (@(posedge ref_clk) disable iff (rst)
      (r_ff.txState == pwmc_pkg::PWMC_TX_SIG && symIf.take && r_ff.sigIdx == `PWMC_SIG_LAST)
      |=> r_ff.txState == pwmc_pkg::PWMC_TX_IDLE) else $error("signature not 8 symbols");

   // decoder side
   chk_space_abort: assert property (@(posedge ref_clk) disable iff (rst)
      (rxRise && r_ff.rxOn && rxSym == pwmc_pkg::PWMC_SYM_SPACE) |=> !rxValid && !rxParityErr && !r_ff.rxOn)
      else $error("frame with space not dropped");
   chk_bcast_take: assert property (@(posedge ref_clk) disable iff (rst)
      (rxRise && r_ff.rxOn && r_ff.rxCnt == `PWMC_LAST_BIT && rxSym != pwmc_pkg::PWMC_SYM_SPACE
      && !(^rxFull) && rxFull[`PWMC_BC_POS]) |=> rxValid && rxBroadcast) else $error("broadcast frame dropped");
endmodule // pwmc_codec

// >>> rtl/pwmc_map.svh
// pwm carrier codec: frame layout, command codes and counter widths
// assumes nothing; included by the package, the codec and the symbol encoder
`ifndef PWMC_MAP_SVH
`define PWMC_MAP_SVH

// ***************************************************************
// frame layout (bit 111 goes out first)
// ***************************************************************
`define PWMC_FRAME_BITS 112
`define PWMC_HDR_BITS 23
`define PWMC_PAY_BITS 88
`define PWMC_CMD_LSB 109
`define PWMC_SRC_LSB 101
`define PWMC_BC_POS 100
`define PWMC_DST_LSB 92
`define PWMC_PAY_LSB 1
`define PWMC_LAST_BIT 7'h6F

// ***************************************************************
// command codes
// ***************************************************************
`define PWMC_CMD_PPS 3'h0
`define PWMC_CMD_READ 3'h2
`define PWMC_CMD_SYNC 3'h3
`define PWMC_CMD_WRITE 3'h4

// ***************************************************************
// signature and counters
// ***************************************************************
`define PWMC_SIG_LEN 8
`define PWMC_SIG_LAST 3'h7
`define PWMC_CNT_W 16
`define PWMC_CNT_MAX 16'hFFFF

`endif

// >>> rtl/pwmc_pkg.sv
// pwm carrier codec: shared types
// assumes pwmc_map.svh is on the include path
package pwmc_pkg;
`include "pwmc_map.svh"

   typedef enum logic [1:0] {
      PWMC_SYM_SPACE = 2'b00,
      PWMC_SYM_ZERO = 2'b01,
      PWMC_SYM_ONE = 2'b10
   } pwmc_sym_e;

   typedef enum logic [1:0] {
      PWMC_TX_IDLE = 2'b00,
      PWMC_TX_SIG = 2'b01,
      PWMC_TX_FRAME = 2'b10
   } pwmc_tx_e;

   typedef struct packed {
      logic cS1;
      logic cS2;
      logic cLast;
      logic [`PWMC_CNT_W-1:0] phase;
      logic [`PWMC_CNT_W-1:0] period;
      pwmc_sym_e sym;
      logic pwm;
   } pwmc_stx_s;

   typedef struct packed {
      pwmc_tx_e txState;
      logic [6:0] bitCnt;
      logic [2:0] sigIdx;
      logic [`PWMC_FRAME_BITS-1:0] txShift;
      logic sigReject;
      logic txBusy;
      logic rS1;
      logic rS2;
      logic rLast;
      logic [`PWMC_CNT_W-1:0] hiCnt;
      logic [`PWMC_CNT_W-1:0] perCnt;
      logic rxOn;
      logic [6:0] rxCnt;
      logic [`PWMC_FRAME_BITS-2:0] rxShift;
      logic rxValid;
      logic [2:0] rxCmd;
      logic [7:0] rxSrc;
      logic rxBc;
      logic [7:0] rxDst;
      logic [`PWMC_PAY_BITS-1:0] rxPay;
      logic rxParityErr;
      logic rxPps;
      logic [1:0] rxTodTarget;
      logic [3:0] rxSyncTarget;
   } pwmc_main_s;
endpackage

// >>> rtl/pwmc_sym_if.sv
// pwm carrier codec: symbol hand-off between sequencer and symbol encoder
// assumes both ends run on ref_clk
`timescale 1ns/1ps
interface pwmc_sym_if;
   pwmc_pkg::pwmc_sym_e sym;
   logic take;
   modport seq (output sym, input take);
   modport enc (input sym, output take);
endinterface

// >>> rtl/pwmc_sym_tx.sv
// pwm carrier codec: per-period symbol encoder on the carrier
// assumes the carrier is asynchronous to ref_clk and at least 8 ref_clk periods long
`timescale 1ns/1ps
`include "pwmc_map.svh"
module pwmc_sym_tx (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // carrier from the dpll
   input wire logic carrierIn,
   // symbol hand-off
   pwmc_sym_if.enc symIf,
   // modulated carrier
   output logic pwmOut
);
   pwmc_pkg::pwmc_stx_s r_ff;
   pwmc_pkg::pwmc_stx_s nxt_r;
   logic rise;
   logic [`PWMC_CNT_W-1:0] fallPt;

   assign rise = r_ff.cS2 & ~r_ff.cLast;
   assign symIf.take = rise;
   assign pwmOut = r_ff.pwm;

   // ***************************************************************
   // falling edge placement
   // ***************************************************************
   always_comb begin
      case (r_ff.sym)
         pwmc_pkg::PWMC_SYM_ZERO: fallPt = r_ff.period >> 2;
         pwmc_pkg::PWMC_SYM_ONE: fallPt = (r_ff.period >> 1) + (r_ff.period >> 2);
         default: fallPt = '0;
      endcase
   end

   always_comb begin
      nxt_r = r_ff;
      nxt_r.cS1 = carrierIn;
      nxt_r.cS2 = r_ff.cS1;
      nxt_r.cLast = r_ff.cS2;
      if (rise) begin
         // rising edge always passes through at fixed latency
         nxt_r.pwm = 1'b1;
         nxt_r.period = r_ff.phase;
         nxt_r.phase = 16'h0001;
         nxt_r.sym = symIf.sym;
      end else begin
         if (r_ff.phase != `PWMC_CNT_MAX) begin
            nxt_r.phase = r_ff.phase + 16'h0001;
         end
         // no period measured yet: send space so nothing bogus leaves
         if (r_ff.sym == pwmc_pkg::PWMC_SYM_SPACE || r_ff.period < 16'h0004) begin
            nxt_r.pwm = r_ff.cS2;
         end else if (r_ff.phase == fallPt) begin
            nxt_r.pwm = 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   // ***************************************************************
   // checks
   // ***************************************************************
   chk_rise_follow: assert property (@(posedge ref_clk) disable iff (rst)
      rise |=> pwmOut) else $error("pwm rising edge not aligned to carrier");
   chk_space_fall: assert property (@(posedge ref_clk) disable iff (rst)
      (r_ff.sym == pwmc_pkg::PWMC_SYM_SPACE && !rise) |=> pwmOut == $past(r_ff.cS2))
      else $error("space symbol falling edge moved");
   chk_zero_duty: assert property (@(posedge ref_clk) disable iff (rst)
      (r_ff.sym == pwmc_pkg::PWMC_SYM_ZERO && r_ff.period >= 16'h0004 && !rise
      && r_ff.phase == (r_ff.period >> 2)) |=> !pwmOut)
      else $error("zero symbol not cut at quarter period");
endmodule // pwmc_sym_tx

// >>> tb/pwmc_far_end.sv
// far-end timing device on the carrier: logs symbols from the codec and sends its own
// assumes an 800 ns carrier shared by both ends
`timescale 1ns/1ps
module pwmc_far_end (
   // carrier
   input wire logic carrierIn,
   // modulated lines
   input wire logic pwmOut,
   output logic pwmIn
);
   logic [1:0] symLog[$];
   logic [111:0] txBits;
   int txLeft = 0;
   int badRise = 0;
   realtime riseAt = -1.0e6;

   // ***************************************************************
   // receive side
   // ***************************************************************
   // gaps of 1000 ns or more (reset, start-up) are not judged
   always @(posedge pwmOut) begin
      if ($realtime - riseAt < 1000.0 && ($realtime - riseAt < 799.0 || $realtime - riseAt > 801.0))
         badRise++;
      riseAt = $realtime;
   end

   always @(negedge pwmOut) begin
      if ($realtime - riseAt < 300.0)
         symLog.push_back(2'b01);
      else if ($realtime - riseAt > 500.0)
         symLog.push_back(2'b10);
      else
         symLog.push_back(2'b00);
   end

   // ***************************************************************
   // send side
   // ***************************************************************
   initial begin
      realtime hi;
      pwmIn = 1'b0;
      forever begin
         @(posedge carrierIn);
         pwmIn = 1'b1;
         hi = 400.0;
         if (txLeft > 0) begin
            hi = txBits[111] ? 600.0 : 200.0;
            txBits = txBits << 1;
            txLeft = txLeft - 1;
         end
         #(hi) pwmIn = 1'b0;
      end
   end

   task automatic send(input logic [111:0] f, input int n);
      txBits = f;
      txLeft = n;
      wait (txLeft == 0);
   endtask
endmodule // pwmc_far_end

// >>> tb/pwmc_codec_tb.sv
// self-checking bench for the pwm carrier codec
// assumes a free-running 800 ns carrier and the far-end model on the same carrier
`timescale 1ns/1ps
module pwmc_codec_tb;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic carrierIn = 1'b0;
   logic pwmOut, pwmIn, sigReject, txBusy, rxValid, rxBroadcast, rxParityErr, rxPps;
   logic sigModeEn = 1'b0;
   logic [15:0] sigPattern = 16'h0000;
   logic ppsIn = 1'b0;
   logic [3:0][87:0] todIn;
   logic [1:0] encTodSel = 2'h0;
   logic [7:0] localEncoderIdentifier = 8'h5A;
   logic broadcastEn = 1'b0;
   logic [7:0] txDstId = 8'h00;
   logic txReq = 1'b0;
   logic [2:0] txCmd = 3'h0;
   logic [87:0] txPayload = 88'h0;
   logic [7:0] localDecoderIdentifier = 8'h3C;
   logic ppsGenEn = 1'b1;
   logic [1:0] rxTodSel = 2'h3;
   logic [3:0] rxSyncSel = 4'h9;
   logic [2:0] rxCmd;
   logic [7:0] rxSrcId;
   logic [87:0] rxPayload;
   logic [1:0] rxTodTarget;
   logic [3:0] rxSyncTarget;
   int badCount = 0;
   int checks = 0;

   initial begin
      forever #50 ref_clk = ~ref_clk;
   end

   // carrier phase is deliberately unrelated to ref_clk
   initial begin
      #137;
      forever #400 carrierIn = ~carrierIn;
   end

   pwmc_codec DUT (.ref_clk(ref_clk), .rst(rst), .carrierIn(carrierIn), .pwmOut(pwmOut), .pwmIn(pwmIn),
      .sigModeEn(sigModeEn), .sigPattern(sigPattern), .sigReject(sigReject), .ppsIn(ppsIn), .todIn(todIn),
      .encTodSel(encTodSel), .localEncoderIdentifier(localEncoderIdentifier), .broadcastEn(broadcastEn),
      .txDstId(txDstId), .txReq(txReq), .txCmd(txCmd), .txPayload(txPayload), .txBusy(txBusy),
      .localDecoderIdentifier(localDecoderIdentifier), .ppsGenEn(ppsGenEn), .rxTodSel(rxTodSel),
      .rxSyncSel(rxSyncSel), .rxValid(rxValid), .rxCmd(rxCmd), .rxSrcId(rxSrcId), .rxBroadcast(rxBroadcast),
      .rxPayload(rxPayload), .rxParityErr(rxParityErr), .rxPps(rxPps), .rxTodTarget(rxTodTarget),
      .rxSyncTarget(rxSyncTarget));

   pwmc_far_end far (.carrierIn(carrierIn), .pwmOut(pwmOut), .pwmIn(pwmIn));

   // ***************************************************************
   // helpers
   // ***************************************************************
   task automatic chk(input string what, input logic [111:0] exp, input logic [111:0] got);
      checks++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         badCount++;
      end
   endtask

   function automatic logic [111:0] mk(input logic [2:0] c, input logic [7:0] s, input logic b,
         input logic [7:0] d, input logic [87:0] p);
      logic [110:0] h;
      h = {c, s, b, d, 3'h0, p};
      return {h, ^h};
   endfunction

   // symbols from the first non-space one; missing symbols read as code 11
   function automatic logic [111:0] grab(input int n, input logic raw);
      logic [111:0] f;
      logic [1:0] s;
      int k;
      f = 112'h0;
      k = 0;
      while (k < far.symLog.size() && far.symLog[k] == 2'b00)
         k++;
      for (int i = 0; i < n; i++) begin
         s = (k + i < far.symLog.size()) ? far.symLog[k + i] : 2'b11;
         f = raw ? {f[109:0], s} : {f[110:0], s[1]};
      end
      return f;
   endfunction

   task automatic waitIdle();
      int n;
      n = 0;
      while (txBusy !== 1'b0 && n < 2000) begin
         @(posedge ref_clk);
         n++;
      end
      chk("txBusy release", 112'h0, txBusy);
      // the last symbol's falling edge lands after busy drops
      repeat (10) @(posedge ref_clk);
   endtask

   // a second request while busy must change nothing
   task automatic sendReq(input logic [2:0] c, input logic [87:0] p, input logic pps, input logic busy);
      far.symLog.delete();
      @(posedge ref_clk);
      txReq <= 1'b1;
      ppsIn <= pps;
      txCmd <= c;
      txPayload <= p;
      @(posedge ref_clk);
      txReq <= 1'b0;
      ppsIn <= 1'b0;
      #1;
      chk("txBusy taken", {111'h0, busy}, txBusy);
      @(posedge ref_clk);
      txReq <= 1'b1;
      txCmd <= 3'h7;
      @(posedge ref_clk);
      txReq <= 1'b0;
      waitIdle();
   endtask

   task automatic rxCase(input logic [111:0] f, input logic v, input logic e, input logic p);
      logic sv, se, sp;
      sv = 1'b0;
      se = 1'b0;
      sp = 1'b0;
      far.send(f, 112);
      repeat (40) begin
         @(posedge ref_clk);
         #1;
         if (rxValid === 1'b1)
            sp = rxPps;
         if (rxValid === 1'b1)
            sv = 1'b1;
         if (rxParityErr === 1'b1)
            se = 1'b1;
      end
      chk("rx pulses", {v, e, p}, {sv, se, sp});
      if (v)
         chk("rx fields", {f[111:100], f[88:1]}, {rxCmd, rxSrcId, rxBroadcast, rxPayload});
   endtask

   // ***************************************************************
   // scenarios
   // ***************************************************************
   task automatic txFrames();
      logic [2:0] cmds [4] = '{3'h0, 3'h2, 3'h3, 3'h4};
      for (int i = 0; i < 4; i++) begin
         @(posedge ref_clk);
         broadcastEn <= i[0];
         txDstId <= {4'h2, i[3:0]};
         sendReq(cmds[i], {11{i[3:0], 4'h6}}, 1'b0, 1'b1);
         chk("frame", mk(cmds[i], 8'h5A, i[0], {4'h2, i[3:0]}, {11{i[3:0], 4'h6}}), grab(112, 1'b0));
      end
   endtask

   task automatic txPps();
      @(posedge ref_clk);
      encTodSel <= 2'h2;
      broadcastEn <= 1'b1;
      txDstId <= 8'h99;
      sendReq(3'h2, {11{8'hEE}}, 1'b1, 1'b1);
      chk("pps frame", mk(3'h0, 8'h5A, 1'b1, 8'h99, todIn[2]), grab(112, 1'b0));
   endtask

   task automatic txSignature();
      @(posedge ref_clk);
      sigModeEn <= 1'b1;
      sigPattern <= 16'h6246;
      sendReq(3'h0, 88'h0, 1'b1, 1'b1);
      chk("signature", 112'h6246, grab(8, 1'b1));
      sigPattern <= 16'h1246;
      sendReq(3'h0, 88'h0, 1'b1, 1'b0);
      chk("signature reject", 112'h1, sigReject);
      chk("nothing sent", 112'h3, grab(1, 1'b1));
      sigModeEn <= 1'b0;
   endtask

   task automatic rxFrames();
      rxCase(mk(3'h0, 8'h77, 1'b0, 8'h3C, {11{8'h5C}}), 1'b1, 1'b0, 1'b1);
      rxCase(mk(3'h3, 8'h78, 1'b1, 8'hE1, {11{8'hA3}}), 1'b1, 1'b0, 1'b0);
      chk("rx targets", {2'h3, 4'h9}, {rxTodTarget, rxSyncTarget});
      rxCase(mk(3'h2, 8'h79, 1'b0, 8'hE1, {11{8'h12}}), 1'b0, 1'b0, 1'b0);
      rxCase(mk(3'h4, 8'h7A, 1'b0, 8'h3C, {11{8'h34}}) ^ 112'h1, 1'b0, 1'b1, 1'b0);
      rxCase(mk(3'h4, 8'h7A, 1'b0, 8'h3C, {11{8'h34}}), 1'b1, 1'b0, 1'b0);
      @(posedge ref_clk);
      ppsGenEn <= 1'b0;
      rxCase(mk(3'h0, 8'h7B, 1'b0, 8'h3C, {11{8'h5C}}), 1'b1, 1'b0, 1'b0);
   endtask

   task automatic testDone();
      if (badCount == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      for (int i = 0; i < 4; i++)
         todIn[i] = {22{i[3:0] ^ 4'hA}};
      repeat (3) @(posedge ref_clk);
      chk("reset outputs", 112'h0, {txBusy, sigReject, rxValid, rxParityErr, rxPps});
      rst <= 1'b0;
      // the encoder sends space until it has captured a carrier period of at least 4 ref_clk cycles
      repeat (30) @(posedge ref_clk);
      txFrames();
      txPps();
      txSignature();
      rxFrames();
      chk("rise spacing", 112'h0, far.badRise);
      testDone();
   end

   // a full run takes about 1 ms
   initial begin
      #4000000;
      badCount++;
      testDone();
   end
endmodule // pwmc_codec_tb
